// file: hdl/cbtm_pkg.sv
// Package for the CAN bit timing and mailbox register block: map, fields, resets, types.
package cbtm_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_TIMING0 = 8'h00;
  localparam logic [7:0] OFS_TIMING1 = 8'h01;
  localparam logic [7:0] OFS_PAGE = 8'h02;
  localparam logic [7:0] OFS_TX_STATUS = 8'h04;
  localparam logic [7:0] OFS_TX_PRIO = 8'h05;
  localparam logic [7:0] OFS_TX_BOX = 8'h10;
  localparam logic [7:0] OFS_RX_BOX = 8'h20;
  // Offsets inside a mailbox window of sixteen bytes.
  localparam logic [3:0] BOX_CTRL = 4'h0;
  localparam logic [3:0] BOX_ID0 = 4'h1;
  localparam logic [3:0] BOX_ID3 = 4'h4;
  localparam logic [3:0] BOX_LEN = 4'h5;
  localparam logic [3:0] BOX_DATA0 = 4'h6;
  localparam logic [3:0] BOX_DATA7 = 4'hD;
  localparam logic [3:0] BOX_STLO = 4'hE;
  localparam logic [3:0] BOX_STHI = 4'hF;
  // Field positions.
  localparam int SEG2_LSB = 4;
  localparam int CS_ERR = 5;
  localparam int CS_ARB = 4;
  localparam int CS_OK = 3;
  localparam int CS_DONE = 2;
  localparam int CS_ABORT = 1;
  localparam int CS_SEND = 0;
  localparam int TS_DONE = 0;
  localparam int TS_OK = 1;
  localparam int LEN_GT = 7;
  // Reset values.
  localparam logic [7:0] RST_TIMING0 = 8'h00;
  localparam logic [7:0] RST_TIMING1 = 8'h23;
  localparam logic [2:0] RST_PAGE = 3'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Field masks for bytes with reserved bits.
  localparam logic [7:0] MASK_TIMING1 = 8'h7F;
  localparam logic [7:0] MASK_ID0 = 8'h7F;
  localparam logic [7:0] MASK_LEN = 8'h8F;
  // Attempt result codes from the protocol engine.
  localparam logic [1:0] RES_OK = 2'h0;
  localparam logic [1:0] RES_ARB = 2'h1;
  localparam logic [1:0] RES_ERR = 2'h2;

  typedef enum logic [1:0] {
    BOX_EMPTY = 2'b00,
    BOX_PENDING = 2'b01,
    BOX_ABORTING = 2'b10
  } cbtm_box_t;

  typedef struct packed {
    logic [7:0] len;
    logic [3:0][7:0] ident;
    logic [7:0][7:0] data;
  } cbtm_msg_t;
endpackage

// file: hdl/cbtm_regs.sv
// CAN bit timing generator and transmit/receive mailbox register file.
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module cbtm_regs #(
  parameter int TIMER_W = 16
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic config_mode_i,
  input wire logic time_triggered_mode_i,
  input wire logic [TIMER_W-1:0] timer_i,
  input wire logic sof_i,
  input wire logic rx_edge_i,
  input wire logic tx_done_i,
  input wire logic [1:0] tx_result_i,
  input wire logic abort_done_i,
  input wire logic rx_store_i,
  input wire cbtm_pkg::cbtm_msg_t rx_msg_i,
  input wire logic [7:0] rx_filter_idx_i,
  output logic quantum_tick_o,
  output logic sample_point_o,
  output logic bit_start_o,
  output logic send_req_o,
  output logic abort_req_o,
  output cbtm_pkg::cbtm_msg_t tx_msg_o,
  output logic [2:0] filter_page_o
);

  if (TIMER_W != 16) begin : g_chk
    $error("cbtm_regs: the time stamp registers hold exactly a 16-bit timer.");
  end

  function automatic logic in_box(input logic [7:0] addr, input logic [7:0] base);
    in_box = (addr[7:4] == base[7:4]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.

  logic [7:0] timing0_ff, timing1_ff, rdata_ff;
  logic [2:0] page_ff;
  cbtm_pkg::cbtm_box_t box_ff, nxt_box;
  logic err_ff, arb_ff, ok_ff, done_ff, send_ff, abort_ff;
  logic [7:0] tx_id_ff [4];
  logic [7:0] tx_len_ff, tx_stlo_ff, tx_sthi_ff;
  logic [7:0] tx_data_ff [8];
  logic [7:0] rx_id_ff [4];
  logic [7:0] rx_len_ff, rx_stlo_ff, rx_sthi_ff, rx_fidx_ff;
  logic [7:0] rx_data_ff [8];
  logic [15:0] sof_hold_ff;
  cbtm_pkg::cbtm_msg_t tx_msg_ff;

  wire [3:0] sub = reg_addr_i[3:0];
  wire tx_sel = in_box(reg_addr_i, cbtm_pkg::OFS_TX_BOX);
  wire rx_sel = in_box(reg_addr_i, cbtm_pkg::OFS_RX_BOX);
  wire box_empty = (box_ff == cbtm_pkg::BOX_EMPTY);
  wire wr_t0 = reg_wr_i && reg_addr_i == cbtm_pkg::OFS_TIMING0 && config_mode_i;
  wire wr_t1 = reg_wr_i && reg_addr_i == cbtm_pkg::OFS_TIMING1;
  wire wr_pg = reg_wr_i && reg_addr_i == cbtm_pkg::OFS_PAGE;
  wire wr_ctl = reg_wr_i && tx_sel && sub == cbtm_pkg::BOX_CTRL;
  wire wr_sts = reg_wr_i && reg_addr_i == cbtm_pkg::OFS_TX_STATUS;
  // Payload writes are refused whole while the mailbox holds a message in flight.
  wire wr_box = reg_wr_i && tx_sel && box_empty && sub != cbtm_pkg::BOX_CTRL;
  wire req_send = wr_ctl && reg_wdata_i[cbtm_pkg::CS_SEND] && box_empty;
  wire req_abort = wr_ctl && reg_wdata_i[cbtm_pkg::CS_ABORT] && !box_empty;
  wire clr_done = (wr_ctl && reg_wdata_i[cbtm_pkg::CS_DONE])
      || (wr_sts && reg_wdata_i[cbtm_pkg::TS_DONE]);
  wire attempt = tx_done_i && !box_empty;
  wire att_ok = attempt && tx_result_i == cbtm_pkg::RES_OK;
  wire finish = att_ok || (!box_empty && abort_done_i)
      || (attempt && box_ff == cbtm_pkg::BOX_ABORTING);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timing0_ff <= cbtm_pkg::RST_TIMING0;
      timing1_ff <= cbtm_pkg::RST_TIMING1;
      page_ff <= cbtm_pkg::RST_PAGE;
    end else begin
      if (wr_t0) begin
        timing0_ff <= reg_wdata_i;
      end
      if (wr_t1) begin
        timing1_ff <= reg_wdata_i & cbtm_pkg::MASK_TIMING1;
      end
      if (wr_pg) begin
        page_ff <= reg_wdata_i[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit timing: quantum divider, position in the bit, resynchronisation.

  logic [5:0] q_cnt_ff, pos_ff, ext_ff, shr_ff;
  logic tick_ff, samp_ff, bstart_ff;
  wire [5:0] presc = {timing0_ff[5:0]};
  wire [5:0] sjw1 = {4'h0, timing0_ff[7:6]} + 6'h01;
  wire [5:0] seg1_len = {2'h0, timing1_ff[3:0]} + 6'h01;
  wire [5:0] seg2_len = {3'h0, timing1_ff[6:4]} + 6'h01;
  wire tick = (q_cnt_ff == presc);
  wire [5:0] seg1_last = seg1_len + ext_ff;
  wire [5:0] bit_last = seg1_last + seg2_len - shr_ff;
  wire in_seg1 = pos_ff != 6'h00 && pos_ff <= seg1_last;
  wire in_seg2 = pos_ff > seg1_last;
  wire [5:0] remain = bit_last - pos_ff + 6'h01;
  wire rs_end = tick && rx_edge_i && in_seg2 && remain <= sjw1;
  wire bit_end = tick && (pos_ff == bit_last || rs_end);

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q_cnt_ff <= 6'h00;
      pos_ff <= 6'h00;
      ext_ff <= 6'h00;
      shr_ff <= 6'h00;
    end else if (config_mode_i) begin
      q_cnt_ff <= 6'h00;
      pos_ff <= 6'h00;
      ext_ff <= 6'h00;
      shr_ff <= 6'h00;
    end else begin
      q_cnt_ff <= tick ? 6'h00 : q_cnt_ff + 6'h01;
      if (bit_end) begin
        pos_ff <= 6'h00;
        ext_ff <= 6'h00;
        shr_ff <= 6'h00;
      end else if (tick) begin
        pos_ff <= pos_ff + 6'h01;
        // A late edge stretches the first segment, an early one trims the second.
        if (rx_edge_i && in_seg1) begin
          ext_ff <= (pos_ff < sjw1) ? pos_ff : sjw1;
        end else if (rx_edge_i && in_seg2) begin
          shr_ff <= sjw1;
        end
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_ff <= 1'b0;
      samp_ff <= 1'b0;
      bstart_ff <= 1'b0;
    end else begin
      tick_ff <= tick && !config_mode_i;
      samp_ff <= tick && !config_mode_i && pos_ff == seg1_last && !bit_end;
      bstart_ff <= bit_end && !config_mode_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit mailbox state and status flags.

  always_comb begin
    nxt_box = box_ff;
    case (box_ff)
      cbtm_pkg::BOX_EMPTY: begin
        if (req_send) begin
          nxt_box = cbtm_pkg::BOX_PENDING;
        end
      end
      cbtm_pkg::BOX_PENDING: begin
        if (finish) begin
          nxt_box = cbtm_pkg::BOX_EMPTY;
        end else if (req_abort) begin
          nxt_box = cbtm_pkg::BOX_ABORTING;
        end
      end
      cbtm_pkg::BOX_ABORTING: begin
        if (finish) begin
          nxt_box = cbtm_pkg::BOX_EMPTY;
        end
      end
      default: begin
        nxt_box = cbtm_pkg::BOX_EMPTY;
      end
    endcase
  end

  // Hardware updates win over a software clear landing in the same cycle.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      box_ff <= cbtm_pkg::BOX_EMPTY;
      send_ff <= 1'b0;
      abort_ff <= 1'b0;
      err_ff <= 1'b0;
      arb_ff <= 1'b0;
      ok_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      box_ff <= nxt_box;
      // Request levels follow the next state, so they move on the same edge as the state.
      send_ff <= nxt_box != cbtm_pkg::BOX_EMPTY;
      abort_ff <= nxt_box == cbtm_pkg::BOX_ABORTING;
      if (attempt) begin
        err_ff <= tx_result_i == cbtm_pkg::RES_ERR;
        arb_ff <= tx_result_i == cbtm_pkg::RES_ARB;
        ok_ff <= att_ok;
      end else if (clr_done || req_send) begin
        err_ff <= 1'b0;
        arb_ff <= 1'b0;
        ok_ff <= 1'b0;
      end else if (wr_ctl) begin
        err_ff <= err_ff && !reg_wdata_i[cbtm_pkg::CS_ERR];
        arb_ff <= arb_ff && !reg_wdata_i[cbtm_pkg::CS_ARB];
        ok_ff <= ok_ff && !reg_wdata_i[cbtm_pkg::CS_OK];
      end
      if (finish) begin
        done_ff <= 1'b1;
      end else if (clr_done || req_send) begin
        done_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mailbox contents.

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sof_hold_ff <= 16'h0000;
      tx_len_ff <= cbtm_pkg::RST_BYTE;
      tx_stlo_ff <= cbtm_pkg::RST_BYTE;
      tx_sthi_ff <= cbtm_pkg::RST_BYTE;
    end else begin
      if (sof_i) begin
        sof_hold_ff <= timer_i;
      end
      if (sof_i && !box_empty) begin
        tx_stlo_ff <= timer_i[7:0];
        tx_sthi_ff <= timer_i[15:8];
      end else if (wr_box && sub == cbtm_pkg::BOX_STLO) begin
        tx_stlo_ff <= reg_wdata_i;
      end else if (wr_box && sub == cbtm_pkg::BOX_STHI) begin
        tx_sthi_ff <= reg_wdata_i;
      end
      if (wr_box && sub == cbtm_pkg::BOX_LEN) begin
        tx_len_ff <= reg_wdata_i & cbtm_pkg::MASK_LEN;
      end
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_byte
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        tx_data_ff[i] <= cbtm_pkg::RST_BYTE;
        rx_data_ff[i] <= cbtm_pkg::RST_BYTE;
      end else begin
        if (wr_box && sub == cbtm_pkg::BOX_DATA0 + 4'(i)) begin
          tx_data_ff[i] <= reg_wdata_i;
        end
        if (rx_store_i) begin
          rx_data_ff[i] <= rx_msg_i.data[i];
        end
      end
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_id
    localparam logic [7:0] ID_MASK = (i == 0) ? cbtm_pkg::MASK_ID0 : 8'hFF;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        tx_id_ff[i] <= cbtm_pkg::RST_BYTE;
        rx_id_ff[i] <= cbtm_pkg::RST_BYTE;
      end else begin
        if (wr_box && sub == cbtm_pkg::BOX_ID0 + 4'(i)) begin
          tx_id_ff[i] <= reg_wdata_i & ID_MASK;
        end
        if (rx_store_i) begin
          rx_id_ff[i] <= rx_msg_i.ident[i] & ID_MASK;
        end
      end
    end
  end

  // Receive side is loaded only by the engine; no write path exists to it.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_len_ff <= cbtm_pkg::RST_BYTE;
      rx_fidx_ff <= cbtm_pkg::RST_BYTE;
      rx_stlo_ff <= cbtm_pkg::RST_BYTE;
      rx_sthi_ff <= cbtm_pkg::RST_BYTE;
    end else if (rx_store_i) begin
      rx_len_ff <= rx_msg_i.len & cbtm_pkg::MASK_LEN;
      rx_fidx_ff <= rx_filter_idx_i;
      rx_stlo_ff <= sof_hold_ff[7:0];
      rx_sthi_ff <= sof_hold_ff[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outgoing frame image and register read port.

  wire send_gt = time_triggered_mode_i && tx_len_ff[cbtm_pkg::LEN_GT];
  logic [7:0] rd_mux;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_msg_ff <= '0;
      rdata_ff <= 8'h00;
    end else begin
      tx_msg_ff.len <= tx_len_ff;
      for (int k = 0; k < 4; k++) begin
        tx_msg_ff.ident[k] <= tx_id_ff[k];
      end
      for (int k = 0; k < 6; k++) begin
        tx_msg_ff.data[k] <= tx_data_ff[k];
      end
      tx_msg_ff.data[6] <= send_gt ? tx_stlo_ff : tx_data_ff[6];
      tx_msg_ff.data[7] <= send_gt ? tx_sthi_ff : tx_data_ff[7];
      if (reg_rd_i) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    if (reg_addr_i == cbtm_pkg::OFS_TIMING0) begin
      rd_mux = config_mode_i ? timing0_ff : 8'h00;
    end else if (reg_addr_i == cbtm_pkg::OFS_TIMING1) begin
      rd_mux = timing1_ff;
    end else if (reg_addr_i == cbtm_pkg::OFS_PAGE) begin
      rd_mux = {5'h00, page_ff};
    end else if (reg_addr_i == cbtm_pkg::OFS_TX_STATUS) begin
      rd_mux = {6'h00, ok_ff, done_ff};
    end else if (reg_addr_i == cbtm_pkg::OFS_TX_PRIO) begin
      rd_mux = {7'h00, box_empty};
    end else if (tx_sel || rx_sel) begin
      if (sub == cbtm_pkg::BOX_CTRL) begin
        rd_mux = tx_sel ? {2'h0, err_ff, arb_ff, ok_ff, done_ff,
            box_ff == cbtm_pkg::BOX_ABORTING, !box_empty} : rx_fidx_ff;
      end else if (sub <= cbtm_pkg::BOX_ID3) begin
        rd_mux = tx_sel ? tx_id_ff[2'(sub - cbtm_pkg::BOX_ID0)]
            : rx_id_ff[2'(sub - cbtm_pkg::BOX_ID0)];
      end else if (sub == cbtm_pkg::BOX_LEN) begin
        rd_mux = tx_sel ? tx_len_ff : rx_len_ff;
      end else if (sub <= cbtm_pkg::BOX_DATA7) begin
        rd_mux = tx_sel ? tx_data_ff[3'(sub - cbtm_pkg::BOX_DATA0)]
            : rx_data_ff[3'(sub - cbtm_pkg::BOX_DATA0)];
      end else if (sub == cbtm_pkg::BOX_STLO) begin
        rd_mux = tx_sel ? tx_stlo_ff : rx_stlo_ff;
      end else begin
        rd_mux = tx_sel ? tx_sthi_ff : rx_sthi_ff;
      end
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign quantum_tick_o = tick_ff;
  assign sample_point_o = samp_ff;
  assign bit_start_o = bstart_ff;
  assign send_req_o = send_ff;
  assign abort_req_o = abort_ff;
  assign tx_msg_o = tx_msg_ff;
  assign filter_page_o = page_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic [6:0] gap_ff;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gap_ff <= 7'h00;
    end else begin
      gap_ff <= (tick || config_mode_i) ? 7'h00 : gap_ff + 7'h01;
    end
  end

  sequence s_attempt_in_flight;
    tx_done_i && box_ff == cbtm_pkg::BOX_PENDING;
  endsequence
  sequence s_send_taken;
    reg_wr_i && tx_sel && sub == cbtm_pkg::BOX_CTRL && reg_wdata_i[0] && box_empty;
  endsequence

  AST_CFG_LOCK: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    reg_wr_i && reg_addr_i == cbtm_pkg::OFS_TIMING0 && !config_mode_i |=> $stable(timing0_ff))
    else $error("Timing byte 0 changed outside configuration mode.");
  AST_QUANTUM: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    tick && !config_mode_i && $stable(presc) |-> gap_ff == {1'b0, presc})
    else $error("Quantum length is not prescaler plus one clocks.");
  AST_RX_PROT: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    reg_wr_i && rx_sel && !rx_store_i |=> $stable(rx_len_ff) && $stable(rx_fidx_ff))
    else $error("Receive mailbox changed on a software write.");
  AST_TX_PROT: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    reg_wr_i && tx_sel && sub == cbtm_pkg::BOX_LEN && !box_empty |=> $stable(tx_len_ff))
    else $error("Busy transmit mailbox accepted a write.");
  AST_DONE_SET: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_attempt_in_flight ##0 tx_result_i == cbtm_pkg::RES_OK |=> done_ff && box_empty && ok_ff)
    else $error("Successful attempt did not complete the request.");
  AST_REQ_CLR: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_send_taken |=> !done_ff && send_req_o ##1 send_req_o || done_ff)
    else $error("New send request did not clear the done flag.");
  AST_ARB: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_attempt_in_flight ##0 tx_result_i == cbtm_pkg::RES_ARB |=> arb_ff && !ok_ff && !err_ff)
    else $error("Lost arbitration not flagged.");
  AST_ABORT_NOP: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    wr_ctl && reg_wdata_i[1] && !reg_wdata_i[0] && box_empty |=> !abort_req_o)
    else $error("Abort took effect on an empty mailbox.");
  AST_STAMP: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    sof_i && !box_empty |=> {tx_sthi_ff, tx_stlo_ff} == $past(timer_i))
    else $error("Start of frame time not captured.");
  AST_SAMPLE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    samp_ff |-> !bstart_ff && !$past(config_mode_i))
    else $error("Sample point coincided with bit start.");

endmodule // cbtm_regs
`default_nettype wire

// file: bench/cbtm_engine_model.sv
// Behavioural model of the protocol engine that serves the transmit mailbox.
`timescale 1ns/1ps
`default_nettype none
module cbtm_engine_model (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic send_req_i,
  input wire logic abort_req_i,
  input wire logic enable_i,
  input wire logic [1:0] result_i,
  output logic sof_o,
  output logic tx_done_o,
  output logic abort_done_o,
  output logic [1:0] tx_result_o
);
  ////////////////////////////////////////////////////////////
  // An attempt ends at step twelve; the idle steps after it let the flags settle before a retry.
  logic [3:0] step_ff;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      step_ff <= 4'h0;
      sof_o <= 1'b0;
      tx_done_o <= 1'b0;
      abort_done_o <= 1'b0;
      tx_result_o <= 2'h0;
    end else begin
      if (step_ff != 4'h0 || (send_req_i && enable_i)) begin
        step_ff <= step_ff + 4'h1;
      end
      sof_o <= (step_ff == 4'h2);
      tx_done_o <= (step_ff == 4'hC) && !abort_req_i;
      abort_done_o <= (step_ff == 4'hC) && abort_req_i;
      // The result code is only meaningful beside the done pulse, so it toggles otherwise.
      tx_result_o <= (step_ff == 4'hC) ? result_i : ~tx_result_o;
    end
  end
endmodule // cbtm_engine_model
`default_nettype wire

// file: bench/tb_cbtm_regs.sv
// Self-checking bench for the bit timing and mailbox register block.
`timescale 1ns/1ps
`default_nettype none
module tb_cbtm_regs;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cfg = 1'b1;
  logic ttm = 1'b0;
  logic store = 1'b0;
  logic en = 1'b0;
  logic edge_in = 1'b0;
  cbtm_pkg::cbtm_msg_t rxm = {8'hF3, 32'hFF1234D6, 64'h0011223344556677};
  logic [1:0] res = cbtm_pkg::RES_OK;
  logic [15:0] timer = 16'h0000;
  logic [15:0] stamp = 16'h0000;
  logic [7:0] rdata;
  logic sof, done, adone, qtick, spt, bstart, sreq, areq;
  logic [1:0] tres;
  logic [2:0] page;
  cbtm_pkg::cbtm_msg_t txm;
  int bad_count = 0;
  int cmp_count = 0;
  int n;
  logic [23:0] rows [10] = '{24'h00C1C1, 24'h01FF7F, 24'h02FF07, 24'h11FF7F, 24'h12A5A5,
    24'h15FF8F, 24'h163C3C, 24'h1DC3C3, 24'h215500, 24'h039900};

  cbtm_regs i_cbtm_regs (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .config_mode_i(cfg), .time_triggered_mode_i(ttm), .timer_i(timer), .sof_i(sof),
    .rx_edge_i(edge_in), .tx_done_i(done), .tx_result_i(tres), .abort_done_i(adone),
    .rx_store_i(store), .rx_msg_i(rxm), .rx_filter_idx_i(8'h5A), .quantum_tick_o(qtick),
    .sample_point_o(spt), .bit_start_o(bstart), .send_req_o(sreq), .abort_req_o(areq),
    .tx_msg_o(txm), .filter_page_o(page));
  cbtm_engine_model i_cbtm_engine_model (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .send_req_i(sreq), .abort_req_i(areq), .enable_i(en), .result_i(res), .sof_o(sof),
    .tx_done_o(done), .abort_done_o(adone), .tx_result_o(tres));
  ////////////////////////////////////////////////////////////
  initial forever #12.5 clock_i = ~clock_i;
  always @(posedge clock_i) timer <= timer + 16'h0001;
  always @(posedge clock_i) if (sof === 1'b1) stamp = timer;

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] e);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata & m);
  endtask
  task automatic attempt();
    n = 0;
    while ((done | adone) !== 1'b1 && n < 100) begin
      @(posedge clock_i);
      n++;
    end
    chk("attempt end", 8'h01, {7'h00, n < 100});
    repeat (2) @(posedge clock_i);
  endtask
  // Measures the spacing of a pulse output; q picks quantum ticks, else bit starts.
  task automatic gap(input string nm, input bit q, input logic [7:0] e);
    int c;
    c = 0;
    while ((q ? qtick : bstart) !== 1'b1) @(posedge clock_i);
    @(posedge clock_i);
    while ((q ? qtick : bstart) !== 1'b1 && c < 400) begin
      @(posedge clock_i);
      c++;
    end
    chk(nm, e, c[7:0] + 8'h01);
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #(20000 * 25);
    bad_count++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rdc("timing1 reset", 8'h01, 8'hFF, 8'h23);
    rdc("empty flag", 8'h05, 8'hFF, 8'h01);
    for (int i = 0; i < 10; i++) begin
      wrt(rows[i][23:16], rows[i][15:8]);
      rdc("row", rows[i][23:16], 8'hFF, rows[i][7:0]);
    end
    chk("page out", 8'h07, {5'h00, page});
    @(posedge clock_i);
    cfg <= 1'b0;
    rdc("timing0 locked", 8'h00, 8'hFF, 8'h00);
    wrt(8'h00, 8'h3F);
    @(posedge clock_i);
    cfg <= 1'b1;
    rdc("timing0 kept", 8'h00, 8'hFF, 8'hC1);
    @(posedge clock_i);
    cfg <= 1'b0;
    gap("quantum", 1'b1, 8'd2);
    gap("bit time", 1'b0, 8'd50);
    while (bstart !== 1'b1) @(posedge clock_i);
    n = 0;
    while (spt !== 1'b1 && n < 400) begin
      @(posedge clock_i);
      n++;
    end
    chk("sample point", 8'h22, n[7:0]);
    @(posedge clock_i);
    edge_in <= 1'b1;
    while (bstart !== 1'b1) @(posedge clock_i);
    @(posedge clock_i);
    n = 1;
    while (bstart !== 1'b1 && n < 400) begin
      @(posedge clock_i);
      n++;
    end
    edge_in <= 1'b0;
    // A resynchronised bit moves by at most the jump width of four quanta, eight clocks.
    chk("resync bit", 8'h01, {7'h00, n != 50 && n >= 42 && n <= 58});
    wrt(8'h1E, 8'h11);
    wrt(8'h1F, 8'h22);
    chk("byte7 plain", 8'hC3, txm.data[7]);
    @(posedge clock_i);
    ttm <= 1'b1;
    repeat (2) @(posedge clock_i);
    chk("stamp lo sent", 8'h11, txm.data[6]);
    chk("stamp hi sent", 8'h22, txm.data[7]);
    wrt(8'h10, 8'h02);
    rdc("abort idle", 8'h10, 8'hFF, 8'h00);
    @(posedge clock_i);
    en <= 1'b1;
    wrt(8'h10, 8'h01);
    wrt(8'h16, 8'h99);
    attempt();
    rdc("ok ctrl", 8'h10, 8'hFF, 8'h0C);
    rdc("ok status", 8'h04, 8'hFF, 8'h03);
    rdc("data kept", 8'h16, 8'hFF, 8'h3C);
    res <= cbtm_pkg::RES_ERR;
    wrt(8'h10, 8'h01);
    rdc("new request", 8'h10, 8'hFF, 8'h01);
    attempt();
    rdc("err ctrl", 8'h10, 8'hFF, 8'h21);
    res <= cbtm_pkg::RES_OK;
    attempt();
    rdc("retry ok", 8'h10, 8'hFF, 8'h0C);
    res <= cbtm_pkg::RES_ARB;
    wrt(8'h10, 8'h01);
    attempt();
    rdc("arb ctrl", 8'h10, 8'h3B, 8'h11);
    wrt(8'h10, 8'h02);
    attempt();
    rdc("aborted", 8'h10, 8'hFF, 8'h14);
    wrt(8'h10, 8'h04);
    rdc("cleared ctrl", 8'h10, 8'hFF, 8'h00);
    rdc("cleared status", 8'h04, 8'hFF, 8'h00);
    @(posedge clock_i);
    store <= 1'b1;
    @(posedge clock_i);
    store <= 1'b0;
    rdc("filter index", 8'h20, 8'hFF, 8'h5A);
    rdc("rx stamp lo", 8'h2E, 8'hFF, stamp[7:0]);
    rdc("rx stamp hi", 8'h2F, 8'hFF, stamp[15:8]);
    rdc("rx length", 8'h25, 8'hFF, 8'h83);
    rdc("rx ident0", 8'h21, 8'hFF, 8'h56);
    rdc("rx data0", 8'h26, 8'hFF, 8'h77);
    conclude();
  end
endmodule // tb_cbtm_regs
`default_nettype wire
